// ===== rtl/ivec_pkg.sv
// Purpose: shared constants for the interrupt vector address logic
// Assumes: 20-bit byte address space, byte-wide vector fetch port
// Notes:   register offsets are word indices on the plain register port
package ivec_pkg;
   // address space and table geometry
   localparam int          IVEC_ADDR_W          = 20;
   localparam logic [19:0] IVEC_FIXED_BASE      = 20'hfffdc; // first fixed entry, top of space
   localparam logic [19:0] IVEC_TABLE_BASE_RST  = 20'h00000;
   localparam logic [7:0]  IVEC_ERASED_BYTE     = 8'hff;     // break entry not programmed
   localparam int          IVEC_EXT_PINS        = 6;
   localparam int          IVEC_SLOTS           = 32;        // peripheral slots 0..31

   // register port offsets
   localparam logic [3:0]  IVEC_REG_TABLE_BASE  = 4'h0;
   localparam logic [3:0]  IVEC_REG_CONTROL     = 4'h1;
   localparam logic [3:0]  IVEC_REG_POLARITY    = 4'h2;
   localparam logic [3:0]  IVEC_REG_LAST_ADDR   = 4'h3;
   localparam logic [3:0]  IVEC_REG_STATUS      = 4'h4;

   // control register fields
   localparam int          IVEC_CTRL_AMATCH_EN  = 0;
   localparam int          IVEC_CTRL_I2C_MODE   = 1;
   localparam int          IVEC_CTRL_CAUSE_8    = 6;  // 1: slot 8 serves pin 5
   localparam int          IVEC_CTRL_CAUSE_9    = 7;  // 1: slot 9 serves pin 4
   localparam logic        IVEC_CTRL_BIT_RST    = 1'b0;
   localparam logic [11:0] IVEC_POLARITY_RST    = 12'h000;

   // status register fields
   localparam int          IVEC_STAT_BUSY       = 0;
   localparam int          IVEC_STAT_NMI        = 1;
   localparam int          IVEC_STAT_KIND_LSB   = 4;
   localparam int          IVEC_STAT_NUM_LSB    = 8;

   // edge polarity codes, two bits per pin
   localparam logic [1:0]  IVEC_POL_FALL        = 2'h0;
   localparam logic [1:0]  IVEC_POL_RISE        = 2'h1;

   // vector request kinds; 0..8 index the fixed table in order
   localparam logic [3:0]  IVEC_KIND_UNDEF      = 4'h0;
   localparam logic [3:0]  IVEC_KIND_OVERFLOW   = 4'h1;
   localparam logic [3:0]  IVEC_KIND_BREAK      = 4'h2;
   localparam logic [3:0]  IVEC_KIND_AMATCH     = 4'h3;
   localparam logic [3:0]  IVEC_KIND_SSTEP      = 4'h4;
   localparam logic [3:0]  IVEC_KIND_WATCHDOG   = 4'h5;
   localparam logic [3:0]  IVEC_KIND_DEBUGGER   = 4'h6;
   localparam logic [3:0]  IVEC_KIND_NMI        = 4'h7;
   localparam logic [3:0]  IVEC_KIND_RESET      = 4'h8;
   localparam logic [3:0]  IVEC_KIND_SOFTWARE   = 4'h9;  // relocatable table, number 0..63

   // slot numbers of the relocatable table
   localparam int          IVEC_SLOT_EXT3       = 4;
   localparam int          IVEC_SLOT_TB_HIGH    = 5;   // timers B5, B4, B3
   localparam int          IVEC_SLOT_SHARED_8   = 8;
   localparam int          IVEC_SLOT_SHARED_9   = 9;
   localparam int          IVEC_SLOT_BUS_COLL   = 10;
   localparam int          IVEC_SLOT_DMA0       = 11;
   localparam int          IVEC_SLOT_KEY        = 13;
   localparam int          IVEC_SLOT_ADC        = 14;
   localparam int          IVEC_SLOT_UART2_TX   = 15;
   localparam int          IVEC_SLOT_UART2_RX   = 16;
   localparam int          IVEC_SLOT_UART0_TX   = 17;
   localparam int          IVEC_SLOT_TIMER_A0   = 21;
   localparam int          IVEC_SLOT_TIMER_B0   = 26;
   localparam int          IVEC_SLOT_EXT0       = 29;
endpackage : ivec_pkg

// ===== rtl/ivec_edge_detect.sv
// Purpose: synchronise one external interrupt pin and detect the selected edge
// Assumes: pin is asynchronous to ref_clk
// Notes:   polarity fall, rise, or both (codes 2 and 3)
`timescale 1ns/100ps
module ivec_edge_detect
   import ivec_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       pin,
   input  wire logic [1:0] polarity,
   output logic            edge_pulse
);
   logic pin_meta;
   logic pin_sync;
   logic pin_prev;

   // two-stage synchroniser, then history for the edge compare
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // one-cycle pulse on the chosen edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         edge_pulse <= 1'b0;
      end else begin
         case (polarity)
            IVEC_POL_FALL: edge_pulse <= pin_prev & ~pin_sync;
            IVEC_POL_RISE: edge_pulse <= ~pin_prev & pin_sync;
            default:       edge_pulse <= pin_prev ^ pin_sync;
         endcase
      end
   end
endmodule : ivec_edge_detect

// ===== rtl/ivec_vector_logic.sv
// Purpose: interrupt source numbering and vector entry fetch for the CPU
// Assumes: acceptance and priority logic outside; it sends one request per accepted event
// Notes:   vector entries are fetched a byte at a time over the mem port
`timescale 1ns/100ps
module ivec_vector_logic
   import ivec_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // external pins, asynchronous
   input  wire logic [5:0]  ext_pin_irq,
   input  wire logic        nmi_pin_n,
   // peripheral request pulses, same clock
   input  wire logic [4:0]  timer_a_irq,
   input  wire logic [5:0]  timer_b_irq,
   input  wire logic [2:0]  uart_tx_irq,
   input  wire logic [2:0]  uart_rx_irq,
   input  wire logic        i2c_nack_irq,
   input  wire logic        i2c_ack_irq,
   input  wire logic        clocked_serial_three_irq,
   input  wire logic        clocked_serial_four_irq,
   input  wire logic        bus_collision_irq,
   input  wire logic [1:0]  dma_irq,
   input  wire logic        key_input_irq,
   input  wire logic        adc_irq,
   // numbered requests toward the acceptance logic
   output logic      [31:0] slot_req,
   output logic             nmi_req,
   // vector request from the acceptance logic
   input  wire logic        vec_req,
   input  wire logic [3:0]  vec_kind,
   input  wire logic [5:0]  vec_num,
   output logic             vec_busy,
   // byte read port to program memory
   output logic      [19:0] mem_addr,
   output logic             mem_rd,
   input  wire logic [7:0]  mem_rdata,
   // routine start address to the CPU
   output logic             branch_valid,
   output logic      [19:0] branch_addr
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WAIT, ST_CHECK} ivec_state_t;

   ivec_state_t state;
   ivec_state_t next_state;

   logic [19:0] vector_table_base;
   logic        amatch_en;
   logic        i2c_mode;
   logic        cause_sel_8;
   logic        cause_sel_9;
   logic [11:0] pin_polarity;
   logic [5:0]  ext_edge;
   logic [31:0] next_slot;
   logic        nmi_meta;
   logic        nmi_sync;
   logic        boot_pending;
   logic [3:0]  cur_kind;
   logic [5:0]  cur_num;
   logic [1:0]  byte_cnt;
   logic [31:0] fetch_data;
   logic        req_ok;
   logic        start;
   logic [3:0]  start_kind;
   logic [5:0]  start_num;
   logic [19:0] start_addr;
   logic        brk_fallback;
   logic [31:0] next_rdata;

   // one edge detector per external pin
   genvar gi;
   generate
      for (gi = 0; gi < IVEC_EXT_PINS; gi++) begin : g_pin
         ivec_edge_detect u_edge (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .pin        (ext_pin_irq[gi]),
            .polarity   (pin_polarity[2*gi +: 2]),
            .edge_pulse (ext_edge[gi])
         );
      end
   endgenerate

   // software-written configuration
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vector_table_base <= IVEC_TABLE_BASE_RST;
         amatch_en         <= IVEC_CTRL_BIT_RST;
         i2c_mode          <= IVEC_CTRL_BIT_RST;
         cause_sel_8       <= IVEC_CTRL_BIT_RST;
         cause_sel_9       <= IVEC_CTRL_BIT_RST;
         pin_polarity      <= IVEC_POLARITY_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            IVEC_REG_TABLE_BASE: vector_table_base <= reg_wdata[19:0];
            IVEC_REG_CONTROL: begin
               amatch_en   <= reg_wdata[IVEC_CTRL_AMATCH_EN];
               i2c_mode    <= reg_wdata[IVEC_CTRL_I2C_MODE];
               cause_sel_8 <= reg_wdata[IVEC_CTRL_CAUSE_8];
               cause_sel_9 <= reg_wdata[IVEC_CTRL_CAUSE_9];
            end
            IVEC_REG_POLARITY: pin_polarity <= reg_wdata[11:0];
            default: ;
         endcase
      end
   end

   // read mux; data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = 32'h0;
      case (reg_addr)
         IVEC_REG_TABLE_BASE: next_rdata[19:0] = vector_table_base;
         IVEC_REG_CONTROL: begin
            next_rdata[IVEC_CTRL_AMATCH_EN] = amatch_en;
            next_rdata[IVEC_CTRL_I2C_MODE]  = i2c_mode;
            next_rdata[IVEC_CTRL_CAUSE_8]   = cause_sel_8;
            next_rdata[IVEC_CTRL_CAUSE_9]   = cause_sel_9;
         end
         IVEC_REG_POLARITY:  next_rdata[11:0] = pin_polarity;
         IVEC_REG_LAST_ADDR: next_rdata[19:0] = branch_addr;
         IVEC_REG_STATUS: begin
            next_rdata[IVEC_STAT_BUSY]                  = vec_busy;
            next_rdata[IVEC_STAT_NMI]                   = nmi_req;
            next_rdata[IVEC_STAT_KIND_LSB +: 4]         = cur_kind;
            next_rdata[IVEC_STAT_NUM_LSB +: 6]          = cur_num;
         end
         default: next_rdata = 32'h0;
      endcase
   end

   // read data register, zero outside the answer cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reg_rdata <= 32'h0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 32'h0;
      end
   end

   // number assignment of peripheral and pin sources; slot 0 and 1..3 never driven here
   always_comb begin
      next_slot = 32'h0;
      next_slot[IVEC_SLOT_EXT3] = ext_edge[3];
      for (int k = 0; k < 3; k++) begin
         next_slot[IVEC_SLOT_TB_HIGH + k] = timer_b_irq[5 - k];
      end
      next_slot[IVEC_SLOT_SHARED_8] = cause_sel_8 ? ext_edge[5] : clocked_serial_four_irq;
      next_slot[IVEC_SLOT_SHARED_9] = cause_sel_9 ? ext_edge[4] : clocked_serial_three_irq;
      next_slot[IVEC_SLOT_BUS_COLL] = bus_collision_irq;
      next_slot[IVEC_SLOT_DMA0]     = dma_irq[0];
      next_slot[IVEC_SLOT_DMA0 + 1] = dma_irq[1];
      next_slot[IVEC_SLOT_KEY]      = key_input_irq;
      next_slot[IVEC_SLOT_ADC]      = adc_irq;
      next_slot[IVEC_SLOT_UART2_TX] = i2c_mode ? i2c_nack_irq : uart_tx_irq[2];
      next_slot[IVEC_SLOT_UART2_RX] = i2c_mode ? i2c_ack_irq : uart_rx_irq[2];
      for (int u = 0; u < 2; u++) begin
         next_slot[IVEC_SLOT_UART0_TX + 2*u]     = uart_tx_irq[u];
         next_slot[IVEC_SLOT_UART0_TX + 2*u + 1] = uart_rx_irq[u];
      end
      for (int t = 0; t < 5; t++) begin
         next_slot[IVEC_SLOT_TIMER_A0 + t] = timer_a_irq[t];
      end
      for (int b = 0; b < 3; b++) begin
         next_slot[IVEC_SLOT_TIMER_B0 + b] = timer_b_irq[b];
         next_slot[IVEC_SLOT_EXT0 + b]     = ext_edge[b];
      end
   end

   // registered slot pulses; all are maskable by the acceptance logic
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slot_req <= 32'h0;
      end else begin
         slot_req <= next_slot;
      end
   end

   // non-maskable pin: synchronised, low level requests
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         nmi_meta <= 1'b1;
         nmi_sync <= 1'b1;
         nmi_req  <= 1'b0;
      end else begin
         nmi_meta <= nmi_pin_n;
         nmi_sync <= nmi_meta;
         nmi_req  <= ~nmi_sync;
      end
   end

   // request qualification; address match needs its enable bit
   always_comb begin
      case (vec_kind)
         IVEC_KIND_AMATCH:   req_ok = amatch_en;
         IVEC_KIND_SOFTWARE: req_ok = 1'b1;
         IVEC_KIND_SSTEP,
         IVEC_KIND_DEBUGGER: req_ok = 1'b1;
         default:            req_ok = (vec_kind <= IVEC_KIND_RESET);
      endcase
   end

   // the reset vector fetch goes first after reset release
   assign start      = (state == ST_IDLE) && (boot_pending || (vec_req && req_ok));
   assign start_kind = boot_pending ? IVEC_KIND_RESET : vec_kind;
   assign start_num  = boot_pending ? 6'h00 : vec_num;
   assign vec_busy   = (state != ST_IDLE) || boot_pending;
   assign mem_rd     = (state == ST_READ);

   // entry address: fixed table by kind, relocatable table by number
   always_comb begin
      if (start_kind == IVEC_KIND_SOFTWARE) begin
         start_addr = vector_table_base + {12'h0, start_num, 2'b00};
      end else begin
         start_addr = IVEC_FIXED_BASE + {14'h0, start_kind, 2'b00};
      end
   end

   // break with an erased fixed entry falls back to relocatable number 0
   assign brk_fallback = (cur_kind == IVEC_KIND_BREAK) &&
                         (fetch_data[7:0] == IVEC_ERASED_BYTE);

   // reset fetch stays pending until the sequencer takes it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         boot_pending <= 1'b1;
      end else if (start) begin
         boot_pending <= 1'b0;
      end
   end

   // fetch sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:  if (start) next_state = ST_READ;
         ST_READ:  next_state = ST_WAIT;
         ST_WAIT:  next_state = (byte_cnt == 2'd3) ? ST_CHECK : ST_READ;
         ST_CHECK: next_state = brk_fallback ? ST_READ : ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   // sequencer state register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // fetch address, byte counter and the request being served
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_addr <= 20'h0;
         byte_cnt <= 2'd0;
         cur_kind <= IVEC_KIND_RESET;
         cur_num  <= 6'h00;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  mem_addr <= start_addr;
                  byte_cnt <= 2'd0;
                  cur_kind <= start_kind;
                  cur_num  <= start_num;
               end
            end
            ST_WAIT: begin
               mem_addr <= mem_addr + 20'h1;
               byte_cnt <= byte_cnt + 2'd1;
            end
            ST_CHECK: begin
               if (brk_fallback) begin
                  mem_addr <= vector_table_base;
                  byte_cnt <= 2'd0;
                  cur_kind <= IVEC_KIND_SOFTWARE;
                  cur_num  <= 6'h00;
               end
            end
            default: ;
         endcase
      end
   end

   // entry assembly, lowest address into the low byte
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fetch_data <= 32'h0;
      end else if (state == ST_WAIT) begin
         fetch_data[8*byte_cnt +: 8] <= mem_rdata;
      end
   end

   // routine start address and its one-cycle strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         branch_valid <= 1'b0;
         branch_addr  <= 20'h0;
      end else begin
         branch_valid <= (state == ST_CHECK) && !brk_fallback;
         if ((state == ST_CHECK) && !brk_fallback) begin
            branch_addr <= fetch_data[19:0];
         end
      end
   end

   // numbers 0 and 32..63 never appear on slot_req; they arrive only as kind 9
   // requests, which the qualification above never refuses, so software numbers
   // stay outside any peripheral mask held by the acceptance logic
endmodule : ivec_vector_logic

// ===== verif/ivec_chk.sv
// Purpose: port checker for the vector address logic
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
module ivec_chk
   import ivec_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        vec_req,
   input wire logic [3:0]  vec_kind,
   input wire logic        vec_busy,
   input wire logic [19:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        branch_valid,
   input wire logic [4:0]  timer_a_irq,
   input wire logic [5:0]  timer_b_irq,
   input wire logic [31:0] slot_req
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // a request counts only while the block is idle
   wire take = vec_req && !vec_busy;

   property p_fixed; take && vec_kind <= 4'h8 && vec_kind != 4'h3
      |=> mem_rd && mem_addr == 20'hfffdc + {14'h0, $past(vec_kind), 2'b00}; endproperty
   a_fixed: assert property (p_fixed) else $error("fixed entry address wrong");
   property p_trap; take && vec_kind == 4'h1 |=> mem_addr == 20'hfffe0; endproperty
   a_trap: assert property (p_trap) else $error("overflow entry address wrong");
   property p_brk; take && vec_kind == 4'h2 |=> mem_addr == 20'hfffe4; endproperty
   a_brk: assert property (p_brk) else $error("break entry address wrong");
   property p_amatch; take && vec_kind == 4'h3 |=> !mem_rd || mem_addr == 20'hfffe8; endproperty
   a_amatch: assert property (p_amatch) else $error("address match entry wrong");
   property p_last; take && vec_kind == 4'h8 |=> mem_addr == 20'hffffc; endproperty
   a_last: assert property (p_last) else $error("reset entry address wrong");
   property p_lat; take && vec_kind != 4'h2 && vec_kind != 4'h3 && vec_kind <= 4'h9
      |=> !branch_valid [*8] ##1 !branch_valid ##1 branch_valid; endproperty
   a_lat: assert property (p_lat) else $error("branch not ten cycles after request");
   property p_pulse; branch_valid |=> !branch_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("branch valid longer than one cycle");
   property p_reads; take && vec_kind <= 4'h9 && vec_kind != 4'h3
      |=> mem_rd ##1 !mem_rd ##1 mem_rd ##1 !mem_rd ##1 mem_rd ##1 !mem_rd ##1 mem_rd; endproperty
   a_reads: assert property (p_reads) else $error("entry not read as four bytes");
   property p_ta; timer_a_irq != 5'h0 |=> slot_req[25:21] == $past(timer_a_irq); endproperty
   a_ta: assert property (p_ta) else $error("timer group one slots wrong");
   property p_tb; timer_b_irq[5:3] != 3'h0
      |=> slot_req[7:5] == {$past(timer_b_irq[3]), $past(timer_b_irq[4]), $past(timer_b_irq[5])}; endproperty
   a_tb: assert property (p_tb) else $error("timer group two high slots wrong");
endmodule : ivec_chk

bind ivec_vector_logic ivec_chk u_chk (
   .ref_clk      (ref_clk),
   .rst          (rst),
   .vec_req      (vec_req),
   .vec_kind     (vec_kind),
   .vec_busy     (vec_busy),
   .mem_addr     (mem_addr),
   .mem_rd       (mem_rd),
   .branch_valid (branch_valid),
   .timer_a_irq  (timer_a_irq),
   .timer_b_irq  (timer_b_irq),
   .slot_req     (slot_req)
);

// ===== verif/ivec_mem_model.sv
// Purpose: program memory answering byte reads of vector entries
// Assumes: read data stand in the cycle after the strobe
// Notes:   between reads the data lines toggle so a stale byte never matches
`timescale 1ns/100ps
module ivec_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        mem_rd,
   input  wire logic [19:0] mem_addr,
   input  wire logic        erased_break,
   output logic      [7:0]  mem_rdata
);
   // program image; break entry low byte may read as erased
   function automatic logic [7:0] image(input logic [19:0] a);
      if (erased_break && a == 20'hfffe4) return 8'hff;
      return a[7:0] ^ a[15:8] ^ {a[19:16], a[3:0]} ^ 8'h5a;
   endfunction : image

   initial mem_rdata = 8'h00;
   // answer one cycle after the strobe, otherwise change every cycle
   always @(posedge ref_clk) begin
      if (mem_rd) mem_rdata <= image(mem_addr);
      else mem_rdata <= ~mem_rdata;
   end
endmodule : ivec_mem_model

// ===== verif/testbench.sv
// Purpose: self-checking bench for the vector address logic
// Assumes: 125 MHz clock, memory model on the fetch port
// Notes:   random values from a fixed-seed xorshift
`timescale 1ns/100ps
module testbench;
   import ivec_pkg::*;
   logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0, vec_kind = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, slot_req, seed = 32'h4, d;
   logic [5:0]  ext_pin_irq = 6'h0, vec_num = 6'h0;
   logic [25:0] src = 26'h0;
   logic        nmi_pin_n = 1'b1, vec_req = 1'b0, erased = 1'b0;
   logic        nmi_req, vec_busy, mem_rd, branch_valid;
   logic [19:0] mem_addr, branch_addr, b;
   logic [7:0]  mem_rdata;
   int          mismatches = 0, n_checks = 0, i, k, p, c, r, f;

   always #4 ref_clk = ~ref_clk;

   ivec_vector_logic DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin_irq(ext_pin_irq),
      .nmi_pin_n(nmi_pin_n), .timer_a_irq(src[4:0]), .timer_b_irq(src[10:5]), .uart_tx_irq(src[13:11]),
      .uart_rx_irq(src[16:14]), .i2c_nack_irq(src[17]), .i2c_ack_irq(src[18]),
      .clocked_serial_three_irq(src[19]), .clocked_serial_four_irq(src[20]), .bus_collision_irq(src[21]),
      .dma_irq(src[23:22]), .key_input_irq(src[24]), .adc_irq(src[25]), .slot_req(slot_req),
      .nmi_req(nmi_req), .vec_req(vec_req), .vec_kind(vec_kind), .vec_num(vec_num), .vec_busy(vec_busy),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .branch_valid(branch_valid),
      .branch_addr(branch_addr));
   ivec_mem_model MEM (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .erased_break(erased),
      .mem_rdata(mem_rdata));

   // xorshift stream
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // expected routine address read from an entry, low byte first
   function automatic logic [19:0] exp_br(input logic [19:0] e);
      logic [19:0] a;
      logic [7:0]  y [3];
      for (int j = 0; j < 3; j++) begin
         a = e + 20'(j);
         y[j] = a[7:0] ^ a[15:8] ^ {a[19:16], a[3:0]} ^ 8'h5a;
      end
      return {y[2][3:0], y[1], y[0]};
   endfunction : exp_br
   // slot reached by one peripheral input, m selects serial bus mode and pin ownership
   function automatic logic [31:0] slot_of(input int j, input bit m);
      int s;
      s = -1;
      if (j < 5) s = 21 + j;
      else if (j < 8) s = 21 + j;
      else if (j < 11) s = 15 - j;
      else if (j < 13) s = 17 + 2 * (j - 11);
      else if (j == 13) s = m ? -1 : 15;
      else if (j < 16) s = 18 + 2 * (j - 14);
      else if (j == 16) s = m ? -1 : 16;
      else if (j < 19) s = m ? j - 2 : -1;
      else if (j < 21) s = m ? -1 : 28 - j;
      else s = j - 11;
      return (s < 0) ? 32'h0 : 32'h1 << s;
   endfunction : slot_of
   // sum of slots expected for a whole input vector
   function automatic logic [31:0] slots_of(input logic [25:0] v, input bit m);
      logic [31:0] o;
      o = 32'h0;
      for (int j = 0; j < 26; j++) if (v[j]) o = o | slot_of(j, m);
      return o;
   endfunction : slots_of

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd
   // count edges until branch valid, bounded
   task automatic wait_br(output int n);
      for (n = 0; n < 25 && branch_valid !== 1'b1; n++) begin
         @(posedge ref_clk);
         #1;
      end
   endtask : wait_br
   // one vector request; lat 0 means the request must be ignored
   task automatic vec(input logic [3:0] kd, input logic [5:0] nm, input logic [19:0] e, input int lat);
      int n;
      for (n = 0; n < 50 && vec_busy !== 1'b0; n++) begin
         @(posedge ref_clk);
         #1;
      end
      if (n == 50) begin
         mismatches++;
         close_out();
      end
      @(posedge ref_clk);
      vec_req  <= 1'b1;
      vec_kind <= kd;
      vec_num  <= nm;
      @(posedge ref_clk);
      vec_req <= 1'b0;
      #1;
      wait_br(n);
      if (lat == 0) chk("ignored request", 32'd25, n);
      if (lat != 0 && n == 25) begin
         mismatches++;
         close_out();
      end
      if (lat != 0) chk("latency", lat, n + 1);
      if (lat != 0) chk("branch address", exp_br(e), branch_addr);
   endtask : vec

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      wait_br(i);
      if (i == 25) begin
         mismatches++;
         close_out();
      end
      chk("reset latency", 32'd10, i + 1);
      chk("reset vector", exp_br(20'hffffc), branch_addr);
      for (k = 0; k < 3; k++) begin
         rd(k[3:0], d);
         chk("register reset value", 32'h0, d);
      end
      rd(4'hf, d);
      chk("unmapped read", 32'h0, d);
      wr(IVEC_REG_CONTROL, 32'h1);
      for (k = 0; k < 9; k++) vec(k[3:0], 6'h0, 20'hfffdc + 20'(4 * k), 10);
      rd(IVEC_REG_LAST_ADDR, d);
      chk("last branch", {12'h0, exp_br(20'hffffc)}, d);
      wr(IVEC_REG_CONTROL, 32'h0);
      vec(4'h3, 6'h0, 20'h0, 0);
      for (r = 0; r < 2; r++) begin
         b = r ? 20'hfffc0 : 20'(rnd());
         wr(IVEC_REG_TABLE_BASE, {12'h0, b});
         for (k = 0; k < 8; k++) begin
            p = k == 0 ? 0 : k == 1 ? 63 : rnd() % 64;
            vec(4'h9, p[5:0], b + 20'(4 * p), 10);
         end
         erased = 1'b1;
         vec(4'h2, 6'h0, b, 19);
         erased = 1'b0;
      end
      for (r = 0; r < 2; r++) begin
         wr(IVEC_REG_CONTROL, r ? 32'hc2 : 32'h0);
         for (k = 0; k < 36; k++) begin
            @(posedge ref_clk);
            d = k < 26 ? 32'h1 << k : rnd();
            src <= d[25:0];
            @(posedge ref_clk);
            src <= 26'h0;
            #1;
            chk("slot request", slots_of(d[25:0], r[0]), slot_req);
            @(posedge ref_clk);
            #1;
            chk("slot request idle", 32'h0, slot_req);
         end
      end
      for (p = 0; p < 6; p++) begin
         for (c = 0; c < 4; c++) begin
            wr(IVEC_REG_POLARITY, 32'(c) << (2 * p));
            repeat (8) @(posedge ref_clk);
            for (r = 1; r >= 0; r--) begin
               @(posedge ref_clk);
               ext_pin_irq[p] <= r[0];
               f = 0;
               repeat (10) begin
                  @(posedge ref_clk);
                  #1;
                  k = p < 3 ? 29 + p : p == 3 ? 4 : p == 4 ? 9 : 8;
                  f += (slot_req[k] === 1'b1);
               end
               chk("pin edge count", (r ? c != 0 : c != 1), f);
            end
         end
      end
      @(posedge ref_clk);
      nmi_pin_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      chk("nmi request", 32'h1, nmi_req);
      rd(IVEC_REG_STATUS, d);
      chk("status", {24'h0, IVEC_KIND_SOFTWARE, 4'h2}, d);
      @(posedge ref_clk);
      nmi_pin_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("nmi release", 32'h0, nmi_req);
      close_out();
   end
endmodule : testbench
